// *** common/qdrd_pkg.sv ***
// constants and types shared by the quad converter command decoder
package qdrd_pkg;

	// ==========================================
	// frame layout
	localparam int          FRAME_BITS  = 24;
	localparam int          RW_POS      = 23;
	localparam int          REG_MSB     = 21;
	localparam int          REG_LSB     = 19;
	localparam int          ADDR_MSB    = 18;
	localparam int          ADDR_LSB    = 16;
	localparam int          DATA_MSB    = 15;
	localparam int          CODE_WIDTH  = 16;
	localparam int          RANGE_MSB   = 2;
	localparam logic [4:0]  LAST_BIT    = 5'h17;

	// ==========================================
	// register select and address codes
	localparam logic [2:0]  REG_CODE    = 3'h0;
	localparam logic [2:0]  REG_RANGE   = 3'h1;
	localparam logic [2:0]  REG_POWER   = 3'h2;
	localparam logic [2:0]  REG_CTRL    = 3'h3;
	localparam logic [2:0]  ADDR_ALL    = 3'h4;
	localparam logic [2:0]  ADDR_POWER  = 3'h0;
	localparam logic [2:0]  CTRL_NOP    = 3'h0;
	localparam logic [2:0]  CTRL_CONFIG = 3'h1;
	localparam logic [2:0]  CTRL_CLEAR  = 3'h4;
	localparam logic [2:0]  CTRL_LOAD   = 3'h5;

	// ==========================================
	// range codes
	localparam logic [2:0]  RANGE_MAX     = 3'h5;
	localparam logic [2:0]  BIPOLAR_FIRST = 3'h3;

	// ==========================================
	// settings and power fields
	localparam int          TSD_EN_POS  = 3;
	localparam int          CLAMP_POS   = 2;
	localparam int          CLR_SEL_POS = 1;
	localparam int          SDO_DIS_POS = 0;
	localparam int          PWR_OC_LSB  = 7;
	localparam int          PWR_TSD_POS = 5;
	localparam int          PWR_PU_LSB  = 0;

	// ==========================================
	// reset values and fixed codes
	localparam logic [3:0]  SETTINGS_RESET = 4'h4;
	localparam logic [2:0]  RANGE_RESET    = 3'h0;
	localparam logic [15:0] CODE_RESET     = 16'h0000;
	localparam logic [3:0]  POWER_RESET    = 4'h0;
	localparam logic [15:0] CODE_ZERO      = 16'h0000;
	localparam logic [15:0] CODE_MID       = 16'h8000;
	localparam logic [23:0] WORD_RESET     = 24'h00_0000;

	typedef enum logic [1:0] {
		QDRD_IDLE  = 2'b00,
		QDRD_SHIFT = 2'b01,
		QDRD_HOLD  = 2'b10
	} qdrd_state_t;

endpackage

// *** verilog/qdrd_bit_sync.sv ***
// two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module qdrd_bit_sync #(
	parameter int               WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT  = '0
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_ff;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_ff <= INIT;
			q       <= INIT;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule // qdrd_bit_sync
`default_nettype wire

// *** verilog/qdrd_top.sv ***
// serial command decoder and register file of a quad voltage-output converter
//
// Behaviour
// - 24-bit frames, MSB first: rw, zero, 3 select, 3 address, 16 data.
// - address 0..3 picks channel A..D, address 4 picks all four.
// - select 000 routes the frame to the conversion code registers.
// - address field picks which channel code register takes the data.
// - code taken from top 16, 14 or 12 data bits; rest ignored.
// - select 001 writes the range code of the addressed channels.
// - range code in data bits 2..0; codes 0..5 select six ranges.
// - select 011 routes the frame to the control function decoder.
// - control address 0 nop, 1 settings, 4 clear, 5 load.
// - no-operation changes no register state.
// - clear loads the clear code into every channel, outputs at once.
// - load moves pending codes into active registers, all together.
// - serial-out disable turns the data output off; default enabled.
// - clamp enabled (default): overcurrent limits, never powers down.
// - clamp disabled: overcurrent powers the channel down.
// - overtemperature shutdown armed only when enabled; default disarmed.
// - clear level 0 gives 0 V; 1 gives midscale or negative full scale.
// - select 010 routes the frame to the power control register.
`timescale 1ns/1ps
`default_nettype none
module qdrd_top #(
	parameter int DATA_BITS = 16
) (
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	input  wire logic        SCLK,
	input  wire logic        SYNC_N,
	input  wire logic        SDIN,
	input  wire logic        TWOS_COMP,
	input  wire logic [3:0]  OVERCURRENT,
	input  wire logic        OVERTEMP,
	output var  logic        SDO,
	output var  logic        SDO_OE_N,
	output var  logic [63:0] ACTIVE_CODE,
	output var  logic [11:0] RANGE_CODE,
	output var  logic [3:0]  CHANNEL_POWER_UP,
	output var  logic        OVERTEMP_SHUTDOWN_ENABLE,
	output var  logic        CLAMP_ENABLE,
	output var  logic        CLEAR_LEVEL_SELECT,
	output var  logic        SERIAL_OUT_DISABLE,
	output var  logic        OVERTEMP_ALERT
);
	// unused low code bits of narrower variants are forced to zero
	localparam logic [15:0] CODE_MASK = 16'(16'hFFFF << (qdrd_pkg::CODE_WIDTH - DATA_BITS));

	// ==========================================
	// synchronisers
	logic [2:0] link_s;
	logic [5:0] stat_s;
	logic       sclk_s;
	logic       sync_n_s;
	logic       sdin_s;
	logic       twos_s;
	logic       ot_s;
	logic [3:0] oc_s;

	// link pins reset to their idle levels, so no false edge or frame follows reset
	qdrd_bit_sync #(.WIDTH(3), .INIT(3'h6)) u_link_sync (
		.clk    (CLK),
		.arst_n (ARST_N),
		.d      ({SCLK, SYNC_N, SDIN}),
		.q      (link_s)
	);

	qdrd_bit_sync #(.WIDTH(6)) u_stat_sync (
		.clk    (CLK),
		.arst_n (ARST_N),
		.d      ({TWOS_COMP, OVERTEMP, OVERCURRENT}),
		.q      (stat_s)
	);

	assign sclk_s   = link_s[2];
	assign sync_n_s = link_s[1];
	assign sdin_s   = link_s[0];
	assign twos_s   = stat_s[5];
	assign ot_s     = stat_s[4];
	assign oc_s     = stat_s[3:0];

	// ==========================================
	// state
	qdrd_pkg::qdrd_state_t state_ff, nxt_state;
	logic [4:0]        bit_cnt_ff,  nxt_bit_cnt;
	logic [22:0]       shift_ff,    nxt_shift;
	logic              sclk_q_ff,   nxt_sclk_q;
	logic [23:0]       sdo_word_ff, nxt_sdo_word;
	logic [23:0]       read_word_ff, nxt_read_word;
	logic              sdo_ff,      nxt_sdo;
	logic              sdo_oe_n_ff, nxt_sdo_oe_n;
	logic [3:0][15:0]  input_ff,    nxt_input;
	logic [3:0][15:0]  active_ff,   nxt_active;
	logic [3:0][2:0]   range_ff,    nxt_range;
	logic [3:0]        settings_ff, nxt_settings;
	logic [3:0]        power_ff,    nxt_power;
	logic              tsd_ff,      nxt_tsd;

	logic        sclk_fall;
	logic        sclk_rise;
	logic        exec;
	logic [23:0] word;
	logic        rw;
	logic [2:0]  rsel;
	logic [2:0]  addr;
	logic [15:0] data;

	// host shifts data in on the falling edge and samples the output on it
	assign sclk_fall = sclk_q_ff & ~sclk_s;
	assign sclk_rise = ~sclk_q_ff & sclk_s;
	assign word      = {shift_ff, sdin_s};
	assign rw        = word[qdrd_pkg::RW_POS];
	assign rsel      = word[qdrd_pkg::REG_MSB:qdrd_pkg::REG_LSB];
	assign addr      = word[qdrd_pkg::ADDR_MSB:qdrd_pkg::ADDR_LSB];
	assign data      = word[qdrd_pkg::DATA_MSB:0];

	// ==========================================
	// clear code per channel
	function automatic logic [15:0] clear_code(
		input logic [2:0] range,
		input logic       level,
		input logic       twos
	);
		logic bipolar;
		bipolar = (range >= qdrd_pkg::BIPOLAR_FIRST);
		if (!bipolar) begin
			clear_code = level ? qdrd_pkg::CODE_MID : qdrd_pkg::CODE_ZERO;
		end else begin
			// 0 V and negative full scale swap codes between the two codings
			clear_code = (level ^ twos) ? qdrd_pkg::CODE_ZERO : qdrd_pkg::CODE_MID;
		end
	endfunction

	// ==========================================
	// frame receiver
	always_comb begin
		nxt_state    = state_ff;
		nxt_bit_cnt  = bit_cnt_ff;
		nxt_shift    = shift_ff;
		nxt_sclk_q   = sclk_s;
		nxt_sdo_word = sdo_word_ff;
		exec         = 1'b0;
		case (state_ff)
			qdrd_pkg::QDRD_IDLE: begin
				if (!sync_n_s) begin
					nxt_state    = qdrd_pkg::QDRD_SHIFT;
					nxt_bit_cnt  = 5'h00;
					nxt_sdo_word = read_word_ff;
				end
			end
			qdrd_pkg::QDRD_SHIFT: begin
				if (sync_n_s) begin
					// a short frame is dropped with no effect
					nxt_state = qdrd_pkg::QDRD_IDLE;
				end else if (sclk_fall) begin
					nxt_shift   = word[22:0];
					nxt_bit_cnt = bit_cnt_ff + 5'h01;
					if (bit_cnt_ff == qdrd_pkg::LAST_BIT) begin
						exec      = 1'b1;
						nxt_state = qdrd_pkg::QDRD_HOLD;
					end
				end else if (sclk_rise && bit_cnt_ff != 5'h00) begin
					nxt_sdo_word = {sdo_word_ff[22:0], 1'b0};
				end
			end
			qdrd_pkg::QDRD_HOLD: begin
				// bits beyond the 24th are ignored until the frame closes
				if (sync_n_s) begin
					nxt_state = qdrd_pkg::QDRD_IDLE;
				end
			end
			default: begin
				nxt_state = qdrd_pkg::QDRD_IDLE;
			end
		endcase
	end

	// ==========================================
	// command decode and register file
	always_comb begin
		nxt_input     = input_ff;
		nxt_active    = active_ff;
		nxt_range     = range_ff;
		nxt_settings  = settings_ff;
		nxt_power     = power_ff;
		nxt_tsd       = tsd_ff;
		nxt_read_word = read_word_ff;
		if (exec && rw) begin
			nxt_read_word = {word[23:16], 16'h0000};
			case (rsel)
				qdrd_pkg::REG_CODE: begin
					if (addr < qdrd_pkg::ADDR_ALL) begin
						nxt_read_word[15:0] = input_ff[addr[1:0]];
					end
				end
				qdrd_pkg::REG_RANGE: begin
					if (addr < qdrd_pkg::ADDR_ALL) begin
						nxt_read_word[2:0] = range_ff[addr[1:0]];
					end
				end
				qdrd_pkg::REG_POWER: begin
					nxt_read_word[qdrd_pkg::PWR_OC_LSB +: 4] = oc_s;
					nxt_read_word[qdrd_pkg::PWR_TSD_POS]     = tsd_ff;
					nxt_read_word[qdrd_pkg::PWR_PU_LSB +: 4] = power_ff;
					nxt_tsd                                  = 1'b0;
				end
				qdrd_pkg::REG_CTRL: begin
					nxt_read_word[3:0] = settings_ff;
				end
				default: begin
					nxt_read_word = read_word_ff;
				end
			endcase
		end else if (exec) begin
			case (rsel)
				qdrd_pkg::REG_CODE: begin
					for (int ch = 0; ch < 4; ch++) begin
						if (addr == 3'(ch) || addr == qdrd_pkg::ADDR_ALL) begin
							nxt_input[ch] = data & CODE_MASK;
						end
					end
				end
				qdrd_pkg::REG_RANGE: begin
					if (data[qdrd_pkg::RANGE_MSB:0] <= qdrd_pkg::RANGE_MAX) begin
						for (int ch = 0; ch < 4; ch++) begin
							if (addr == 3'(ch) || addr == qdrd_pkg::ADDR_ALL) begin
								nxt_range[ch] = data[qdrd_pkg::RANGE_MSB:0];
							end
						end
					end
				end
				qdrd_pkg::REG_POWER: begin
					if (addr == qdrd_pkg::ADDR_POWER) begin
						nxt_power = data[qdrd_pkg::PWR_PU_LSB +: 4];
					end
				end
				qdrd_pkg::REG_CTRL: begin
					case (addr)
						qdrd_pkg::CTRL_NOP: begin
							nxt_input = input_ff;
						end
						qdrd_pkg::CTRL_CONFIG: begin
							nxt_settings = data[3:0];
						end
						qdrd_pkg::CTRL_CLEAR: begin
							for (int ch = 0; ch < 4; ch++) begin
								nxt_input[ch]  = clear_code(range_ff[ch],
									settings_ff[qdrd_pkg::CLR_SEL_POS], twos_s);
								nxt_active[ch] = nxt_input[ch];
							end
						end
						qdrd_pkg::CTRL_LOAD: begin
							nxt_active = input_ff;
						end
						default: begin
							nxt_settings = settings_ff;
						end
					endcase
				end
				default: begin
					nxt_settings = settings_ff;
				end
			endcase
		end
		// hardware power-down events act after the command, so they win
		if (!settings_ff[qdrd_pkg::CLAMP_POS]) begin
			nxt_power = nxt_power & ~oc_s;
		end
		if (settings_ff[qdrd_pkg::TSD_EN_POS] && ot_s) begin
			nxt_power = qdrd_pkg::POWER_RESET;
			nxt_tsd   = 1'b1;
		end
	end

	// ==========================================
	// serial output
	always_comb begin
		nxt_sdo      = nxt_sdo_word[23];
		nxt_sdo_oe_n = nxt_settings[qdrd_pkg::SDO_DIS_POS]
			| (nxt_state == qdrd_pkg::QDRD_IDLE);
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_ff     <= qdrd_pkg::QDRD_IDLE;
			bit_cnt_ff   <= 5'h00;
			shift_ff     <= 23'h00_0000;
			sclk_q_ff    <= 1'b1;
			sdo_word_ff  <= qdrd_pkg::WORD_RESET;
			read_word_ff <= qdrd_pkg::WORD_RESET;
			sdo_ff       <= 1'b0;
			sdo_oe_n_ff  <= 1'b1;
			input_ff     <= {4{qdrd_pkg::CODE_RESET}};
			active_ff    <= {4{qdrd_pkg::CODE_RESET}};
			range_ff     <= {4{qdrd_pkg::RANGE_RESET}};
			settings_ff  <= qdrd_pkg::SETTINGS_RESET;
			power_ff     <= qdrd_pkg::POWER_RESET;
			tsd_ff       <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			bit_cnt_ff   <= nxt_bit_cnt;
			shift_ff     <= nxt_shift;
			sclk_q_ff    <= nxt_sclk_q;
			sdo_word_ff  <= nxt_sdo_word;
			read_word_ff <= nxt_read_word;
			sdo_ff       <= nxt_sdo;
			sdo_oe_n_ff  <= nxt_sdo_oe_n;
			input_ff     <= nxt_input;
			active_ff    <= nxt_active;
			range_ff     <= nxt_range;
			settings_ff  <= nxt_settings;
			power_ff     <= nxt_power;
			tsd_ff       <= nxt_tsd;
		end
	end

	// ==========================================
	// outputs
	assign SDO                      = sdo_ff;
	assign SDO_OE_N                 = sdo_oe_n_ff;
	assign ACTIVE_CODE              = active_ff;
	assign RANGE_CODE               = range_ff;
	assign CHANNEL_POWER_UP         = power_ff;
	assign OVERTEMP_SHUTDOWN_ENABLE = settings_ff[qdrd_pkg::TSD_EN_POS];
	assign CLAMP_ENABLE             = settings_ff[qdrd_pkg::CLAMP_POS];
	assign CLEAR_LEVEL_SELECT       = settings_ff[qdrd_pkg::CLR_SEL_POS];
	assign SERIAL_OUT_DISABLE       = settings_ff[qdrd_pkg::SDO_DIS_POS];
	assign OVERTEMP_ALERT           = tsd_ff;
endmodule // qdrd_top
`default_nettype wire

// *** sim/qdrd_host_model.sv ***
// serial host model that shifts command frames into the decoder
`timescale 1ns/1ps
`default_nettype none
module qdrd_host_model (
	input  wire logic        sdo,
	output var  logic        sclk,
	output var  logic        sync_n,
	output var  logic        sdin,
	output var  logic [23:0] rdata
);
	initial begin
		sclk = 1'h1;
		sync_n = 1'h1;
		sdin = 1'h0;
		rdata = 24'h00_0000;
	end
	// rdata keeps the last 24 bits seen on sdo at falling clock edges
	// n below 24 cuts the frame short; hp sets the half period
	task automatic send(input logic [23:0] x, input int n = 24, input int hp = 40);
		#3;
		sync_n = 1'h0;
		#(hp);
		for (int i = 0; i < n; i++) begin
			sdin = (i == 1) ? 1'h0 : x[23 - i];
			#(hp) sclk = 1'h0;
			rdata = {rdata[22:0], sdo};
			#(hp) sclk = 1'h1;
		end
		#(hp) sync_n = 1'h1;
		// released line must not look held
		sdin = ~sdin;
		// whole frame is a multiple of the clock period, so pins never move on a sampling edge
		#(4 * hp - 3);
	endtask
endmodule // qdrd_host_model
`default_nettype wire

// *** sim/qdrd_top_assertions.sv ***
// assertions on the ports of the command decoder top
`timescale 1ns/1ps
`default_nettype none
module qdrd_top_checker #(
	parameter int DATA_BITS = 16
) (
	input wire logic        CLK,
	input wire logic        ARST_N,
	input wire logic        SYNC_N,
	input wire logic [3:0]  OVERCURRENT,
	input wire logic        OVERTEMP,
	input wire logic        SDO_OE_N,
	input wire logic [63:0] ACTIVE_CODE,
	input wire logic [11:0] RANGE_CODE,
	input wire logic [3:0]  CHANNEL_POWER_UP,
	input wire logic        OVERTEMP_SHUTDOWN_ENABLE,
	input wire logic        CLAMP_ENABLE,
	input wire logic        CLEAR_LEVEL_SELECT,
	input wire logic        SERIAL_OUT_DISABLE,
	input wire logic        OVERTEMP_ALERT
);
	// ==========================================
	// properties
	localparam logic [15:0] LOW = 16'((32'h1 << (16 - DATA_BITS)) - 32'h1);
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	reset_values_a: assert property (disable iff (1'h0) !ARST_N [*2] |-> CLAMP_ENABLE
		&& SDO_OE_N && !OVERTEMP_SHUTDOWN_ENABLE && !SERIAL_OUT_DISABLE
		&& ACTIVE_CODE == 64'h0) else $error("reset values");
	frame_end_a: assert property (!$stable({ACTIVE_CODE, RANGE_CODE, OVERTEMP_SHUTDOWN_ENABLE, CLAMP_ENABLE,
		CLEAR_LEVEL_SELECT, SERIAL_OUT_DISABLE}) |-> !$past(SYNC_N, 2)) else $error("update outside frame");
	sdo_off_a: assert property (SERIAL_OUT_DISABLE [*2] |-> SDO_OE_N) else $error("sdo driven");
	sdo_idle_a: assert property (SYNC_N [*5] |-> SDO_OE_N) else $error("sdo driven idle");
	sdo_drive_a: assert property ((!SYNC_N && !SERIAL_OUT_DISABLE) [*5] |-> !SDO_OE_N)
		else $error("sdo not driven in frame");
	clamp_off_a: assert property ((!CLAMP_ENABLE && OVERCURRENT != 4'h0 && $stable(OVERCURRENT)) [*4]
		|-> (CHANNEL_POWER_UP & OVERCURRENT) == 4'h0) else $error("overcurrent kept power");
	clamp_on_a: assert property ((CLAMP_ENABLE && SYNC_N && !OVERTEMP_SHUTDOWN_ENABLE) [*6]
		|-> $stable(CHANNEL_POWER_UP)) else $error("power changed with clamp");
	tsd_off_a: assert property (!OVERTEMP_SHUTDOWN_ENABLE [*4] |-> !$rose(OVERTEMP_ALERT)) else $error("alert");
	tsd_on_a: assert property ((OVERTEMP_SHUTDOWN_ENABLE && OVERTEMP) [*4]
		|-> OVERTEMP_ALERT && CHANNEL_POWER_UP == 4'h0) else $error("no shutdown");
	low_bits_a: assert property ((ACTIVE_CODE & {4{LOW}}) == 64'h0) else $error("low code bits");
	range_legal_a: assert property (RANGE_CODE[2:0] <= 3'h5 && RANGE_CODE[5:3] <= 3'h5
		&& RANGE_CODE[8:6] <= 3'h5 && RANGE_CODE[11:9] <= 3'h5) else $error("range code");
	cover property (SERIAL_OUT_DISABLE && !SYNC_N);
	cover property (!CLAMP_ENABLE && OVERCURRENT != 4'h0);
	cover property (OVERTEMP_ALERT);
	cover property (!SDO_OE_N && !SYNC_N);
endmodule // qdrd_top_checker
bind qdrd_top qdrd_top_checker #(.DATA_BITS(DATA_BITS)) chk_i (.CLK(CLK), .ARST_N(ARST_N), .SYNC_N(SYNC_N),
	.OVERCURRENT(OVERCURRENT), .OVERTEMP(OVERTEMP), .SDO_OE_N(SDO_OE_N), .ACTIVE_CODE(ACTIVE_CODE),
	.RANGE_CODE(RANGE_CODE), .CHANNEL_POWER_UP(CHANNEL_POWER_UP), .OVERTEMP_SHUTDOWN_ENABLE(OVERTEMP_SHUTDOWN_ENABLE),
	.CLAMP_ENABLE(CLAMP_ENABLE), .CLEAR_LEVEL_SELECT(CLEAR_LEVEL_SELECT),
	.SERIAL_OUT_DISABLE(SERIAL_OUT_DISABLE), .OVERTEMP_ALERT(OVERTEMP_ALERT));
`default_nettype wire

// *** sim/qdrd_top_bench.sv ***
// self-checking bench for the command decoder top
`timescale 1ns/1ps
`default_nettype none
module qdrd_top_bench;
	// 14-bit variant so that ignored low data bits are exercised
	localparam int          DB   = 14;
	localparam logic [15:0] MASK = ~16'((32'h1 << (16 - DB)) - 32'h1);
	logic        clk = 1'h0, arst_n = 1'h0, twos = 1'h0, oth = 1'h0;
	logic [3:0]  oc = 4'h0, pu;
	logic        sdo, sdo_oe_n, tsd, clamp, clr, sdis, alert;
	logic [63:0] code, exp;
	logic [11:0] rng, erng;
	logic [95:0] snap;
	logic [23:0] bad [8];
	wire         sclk, sync_n, sdin;
	wire  [23:0] rd;
	int          n_fail = 0, checks = 0;
	always #5 clk = ~clk;
	qdrd_host_model host (.sdo(sdo), .sclk(sclk), .sync_n(sync_n), .sdin(sdin), .rdata(rd));
	qdrd_top #(.DATA_BITS(DB)) dut (.CLK(clk), .ARST_N(arst_n), .SCLK(sclk), .SYNC_N(sync_n), .SDIN(sdin),
		.TWOS_COMP(twos), .OVERCURRENT(oc), .OVERTEMP(oth), .SDO(sdo), .SDO_OE_N(sdo_oe_n), .ACTIVE_CODE(code),
		.RANGE_CODE(rng), .CHANNEL_POWER_UP(pu), .OVERTEMP_SHUTDOWN_ENABLE(tsd), .CLAMP_ENABLE(clamp),
		.CLEAR_LEVEL_SELECT(clr), .SERIAL_OUT_DISABLE(sdis), .OVERTEMP_ALERT(alert));
	// ==========================================
	// helpers
	function automatic logic [23:0] w(input logic [2:0] s, input logic [2:0] a, input logic [15:0] d);
		return {2'h0, s, a, d};
	endfunction
	function automatic logic [15:0] cc(input logic [2:0] r, input logic l, input logic t);
		logic [15:0] z;
		z = (r >= 3'h3 && !t) ? 16'h8000 : 16'h0000;
		return l ? ((r >= 3'h3) ? (z ^ 16'h8000) : 16'h8000) : z;
	endfunction
	task automatic chk(input logic [95:0] got, input logic [95:0] want);
		checks++;
		if (got !== want) begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic pins(input logic [3:0] o, input logic t);
		@(negedge clk);
		oc = o;
		oth = t;
		repeat (10) @(negedge clk);
	endtask
	task automatic results;
		$display("mismatches %0d comparisons %0d", n_fail, checks);
		if (n_fail == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		results;
	end
	// ==========================================
	// scenarios
	initial begin
		bad = '{w(3'h4, 3'h0, 16'hffff), w(3'h7, 3'h4, 16'hffff), w(3'h3, 3'h2, 16'hffff), w(3'h3, 3'h6, 16'hffff),
			w(3'h3, 3'h0, 16'hffff), w(3'h0, 3'h5, 16'hffff), w(3'h2, 3'h1, 16'h000f), w(3'h3, 3'h7, 16'hffff)};
		repeat (4) @(negedge clk);
		arst_n = 1'h1;
		repeat (4) @(negedge clk);
		chk(96'({tsd, clamp, clr, sdis, pu, rng, code}), 96'({4'h4, 4'h0, 12'h0, 64'h0}));
		for (int a = 0; a < 4; a++) begin
			host.send(w(3'h0, 3'(a), {4{4'(a + 9)}}));
			exp[a * 16 +: 16] = {4{4'(a + 9)}} & MASK;
		end
		chk(96'(code), 96'h0);
		host.send(w(3'h3, 3'h5, 16'h0));
		chk(96'(code), 96'(exp));
		host.send(w(3'h0, 3'h4, 16'h5a5b));
		host.send(w(3'h3, 3'h5, 16'h0), 24, 200);
		exp = {4{16'h5a5b & MASK}};
		chk(96'(code), 96'(exp));
		host.send(w(3'h0, 3'h1, 16'h1234), 23);
		host.send(w(3'h3, 3'h5, 16'h0), 20);
		host.send(w(3'h3, 3'h5, 16'h0));
		chk(96'(code), 96'(exp));
		erng = 12'h0;
		for (int r = 0; r < 8; r++) begin
			host.send(w(3'h1, 3'h4, 16'hfff8 | 16'(r)));
			if (r < 6)
				erng = {4{3'(r)}};
			chk(96'(rng), 96'(erng));
		end
		host.send(w(3'h1, 3'h0, 16'h0));
		host.send(w(3'h1, 3'h1, 16'h0003));
		host.send(w(3'h1, 3'h2, 16'h0005));
		host.send(w(3'h1, 3'h3, 16'h0001));
		chk(96'(rng), 96'h358);
		host.send(24'h80_0000 | w(3'h1, 3'h2, 16'h0));
		snap = {tsd, clamp, clr, sdis, pu, rng, code};
		for (int i = 0; i < 8; i++)
			host.send(bad[i]);
		host.send(w(3'h3, 3'h5, 16'h0));
		chk({tsd, clamp, clr, sdis, pu, rng, code}, snap);
		chk(96'(rd), 96'h8a_0005);
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			twos = i[1];
			host.send(w(3'h3, 3'h1, {14'h1, i[0], 1'h0}));
			host.send(w(3'h3, 3'h4, 16'hffff));
			chk(96'(clr), 96'(i[0]));
			chk(96'(code), 96'({cc(3'h1, i[0], i[1]), cc(3'h5, i[0], i[1]), cc(3'h3, i[0], i[1]),
				cc(3'h0, i[0], i[1])}));
		end
		host.send(w(3'h2, 3'h0, 16'h000f));
		chk(96'(pu), 96'hf);
		pins(4'h1, 1'h0);
		chk(96'(pu), 96'hf);
		host.send(w(3'h3, 3'h1, 16'h0));
		chk(96'(pu), 96'he);
		pins(4'h0, 1'h0);
		host.send(w(3'h3, 3'h1, 16'h0004));
		pins(4'h0, 1'h1);
		chk(96'({alert, pu}), 96'h0e);
		host.send(w(3'h3, 3'h1, 16'h000c));
		pins(4'h0, 1'h1);
		chk(96'({alert, pu}), 96'h10);
		pins(4'h0, 1'h0);
		host.send(24'h80_0000 | w(3'h2, 3'h0, 16'h0));
		chk(96'(alert), 96'h0);
		host.send(w(3'h3, 3'h1, 16'h0005));
		chk(96'(rd), 96'h90_0020);
		host.send(w(3'h3, 3'h0, 16'h0));
		chk(96'({sdis, sdo_oe_n}), 96'h3);
		results;
	end
endmodule // qdrd_top_bench
`default_nettype wire
